//--- hdl/etc_pkg.sv
// Purpose: shared constants for the compare/PWM timer block
// Assumes: 16-bit register port, word-indexed addresses
// Notes: all offsets, fields, resets and counts live here
package etc_pkg;

   // Register port and counter widths
   localparam int ADDR_W = 3;
   localparam int DATA_W = 16;
   localparam int CNT_W = 10;
   localparam int EXT_W = 11;

   // Register offsets
   localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
   localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
   localparam logic [2:0] ADDR_CMP_A = 3'h2;
   localparam logic [2:0] ADDR_CMP_B = 3'h3;
   localparam logic [2:0] ADDR_COUNT = 3'h4;
   localparam logic [2:0] ADDR_FLAGS = 3'h5;

   // Channel control fields (both control registers)
   localparam int F_MODE_LO = 0;
   localparam int F_ACTION_LO = 2;
   localparam int F_OUT_CTRL = 4;
   localparam int F_POLARITY = 5;
   // Extra fields of control register one
   localparam int F_PSEL = 6;
   localparam int F_RUN = 7;
   localparam int F_PCODE_LO = 8;
   localparam int F_ALIGN_LO = 11;
   // Flag register fields
   localparam int F_FLAG_A = 0;
   localparam int F_FLAG_B = 1;
   localparam int F_FLAG_P = 2;

   // Reset values
   localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
   localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
   localparam logic [9:0] RST_CMP = 10'h000;

   // Mode field codes
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TIMER = 2'h3;

   // Output action codes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] ACT_PWM_INACT = 2'h0;
   localparam logic [1:0] ACT_PWM_ACT = 2'h1;
   localparam logic [1:0] ACT_PWM_WAVE = 2'h2;

   // Alignment codes
   localparam logic [1:0] ALIGN_EDGE = 2'h0;

   // Period arithmetic
   localparam logic [10:0] PERIOD_STEP = 11'h080;
   localparam logic [10:0] FULL_SPAN = 11'h400;

endpackage

//--- hdl/etc_link_if.sv
// Purpose: counter state shared by the counter and output channels
// Assumes: single clock domain
// Notes: top drives start, counter drives count and direction
`timescale 1ns/10ps
interface etc_link_if;
   import etc_pkg::*;
   logic [EXT_W-1:0] cnt; // Live count, one spare bit for the centre peak
   logic up;              // Counting direction
   logic start;           // Run-bit rising edge, one cycle

   modport ctr (output cnt, output up, input start);
   modport chan (input cnt, input up, input start);
endinterface

//--- hdl/etc_counter.sv
// Purpose: up or up/down counter with the three comparators
// Assumes: tick_i already qualified with the clock enable
// Notes: match outputs are one-cycle pulses on the counting cycle
`timescale 1ns/10ps
module etc_counter
   import etc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Control
   input wire logic step_i,
   input wire logic centre_i,
   input wire logic [1:0] align_i,
   input wire logic psel_i,
   input wire logic [2:0] pcode_i,
   input wire logic [CNT_W-1:0] cmp_a_i,
   input wire logic [CNT_W-1:0] cmp_b_i,
   // Counter state
   etc_link_if.ctr link,
   // Match pulses
   output logic match_a_o,
   output logic match_b_o,
   output logic match_p_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [EXT_W-1:0] top; // Period length (edge) or peak (centre)
   logic [EXT_W-1:0] nxt; // Value after this step
   logic dir_ok; // Direction allows A/B matches
   logic wrap; // Edge period end
   logic bottom; // Centre count lands on zero

   // Period: compare A or code times step, code zero is full span
   always_comb begin
      if (psel_i) begin
         top = (cmp_a_i == '0) ? FULL_SPAN : {1'b0, cmp_a_i};
      end else if (pcode_i == 3'h0) begin
         top = FULL_SPAN;
      end else begin
         top = 11'(PERIOD_STEP * pcode_i);
      end
   end

   // Next value and comparator decode
   always_comb begin
      nxt = (centre_i && !link.up) ? link.cnt - 11'h001 : link.cnt + 11'h001;
      wrap = !centre_i && (nxt == top);
      bottom = centre_i && !link.up && (nxt == '0);
      // Centre matches filtered by direction
      dir_ok = !centre_i || (align_i[0] && link.up) || (align_i[1] && !link.up);
      match_a_o = step_i && dir_ok && (nxt[CNT_W-1:0] == cmp_a_i) && !nxt[CNT_W];
      match_b_o = step_i && dir_ok && (nxt[CNT_W-1:0] == cmp_b_i) && !nxt[CNT_W];
      // No period match when compare A owns the period
      match_p_o = step_i && !psel_i && (wrap || bottom);
   end

   ////////////////////////////////////////////////////////////////////////
   // Count register, restarted from zero by the run edge
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         link.cnt <= '0;
         link.up <= 1'b1;
      end else if (link.start) begin
         link.cnt <= '0;
         link.up <= 1'b1;
      end else if (step_i) begin
         if (wrap) begin
            link.cnt <= '0;
         end else begin
            link.cnt <= nxt;
         end
         // Turn at the peak and at zero
         if (centre_i && link.up && nxt == top) begin
            link.up <= 1'b0;
         end else if (bottom) begin
            link.up <= 1'b1;
         end
      end
   end

endmodule

//--- hdl/etc_channel.sv
// Purpose: one output pin of the timer, compare actions or PWM
// Assumes: match_i is a one-cycle pulse from the counter
// Notes: pin and enable are registered; PWM lags the count by one cycle
`timescale 1ns/10ps
module etc_channel
   import etc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Channel settings
   input wire logic [1:0] mode_i,
   input wire logic [1:0] action_i,
   input wire logic out_ctrl_i,
   input wire logic polarity_i,
   input wire logic [CNT_W-1:0] cmp_i,
   input wire logic no_pwm_i,
   input wire logic match_i,
   // Counter state
   etc_link_if.chan link,
   // Pin
   output logic pin_o,
   output logic pin_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   logic active; // Duty window open
   logic act_lvl; // Active level after polarity

   // Pulse lies below the compare value: edge pulses start at zero
   always_comb begin
      active = link.cnt < {1'b0, cmp_i};
      act_lvl = out_ctrl_i ^ polarity_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive enable: capture and timer modes leave the pin alone
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         pin_oe_o <= (mode_i == MODE_COMPARE) || (mode_i == MODE_PWM);
      end
   end

   // Pin level
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pin_o <= 1'b0;
      end else if (ce_i) begin
         case (mode_i)
            MODE_COMPARE: begin
               if (link.start) begin
                  pin_o <= out_ctrl_i;
               end else if (match_i) begin
                  case (action_i)
                     ACT_LOW: pin_o <= 1'b0;
                     ACT_HIGH: pin_o <= 1'b1;
                     ACT_TOGGLE: pin_o <= ~pin_o;
                     default: pin_o <= pin_o;
                  endcase
               end
            end
            MODE_PWM: begin
               case (action_i)
                  ACT_PWM_ACT: pin_o <= act_lvl;
                  ACT_PWM_WAVE: begin
                     // Period-owning channel shows no waveform
                     if (no_pwm_i) begin
                        pin_o <= ~act_lvl;
                     end else begin
                        pin_o <= active ? act_lvl : ~act_lvl;
                     end
                  end
                  default: pin_o <= ~act_lvl;
               endcase
            end
            default: pin_o <= pin_o;
         endcase
      end
   end

endmodule

//--- hdl/etc_top.sv
// Purpose: dual-channel compare-match and PWM timer with register port
// Assumes: tick_i comes from logic on core_clk_i, one cycle per count
// Notes: registers are word indexed; read data stands one cycle later
//
// Notes on behaviour
// - Period-select low: P match or overflow clears.
// - Period-select high: A clears; no P flag.
// - Compare pins move only on own match.
// - Action field sets, clears or toggles pin.
// - Action zero leaves pin unchanged on match.
// - Run rising edge loads initial pin level.
// - Timer mode counts alike, pins undriven.
// - Period-select high: A period, B duty only.
// - Edge period from code, 000 gives 1024.
// - Edge period equals compare A value.
// - Centre period doubled; duty twice compare minus one.
// - Centre with A period: twice A, A zero gives 2048.
// - Edge pulses start together at counter zero.
// - PWM raises A, B and P match flags.
// - Action passes PWM or forces pin level.
// - Polarity bit inverts the PWM output.
// - Counting and flags continue with actions 00/01.
// - Alignment: 00 edge, else centre up/down/both.
// - Counter and compare values are ten bits.
`timescale 1ns/10ps
module etc_top
   import etc_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   // Timer clock strobe
   input wire logic tick_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   // Output pins
   output logic output_pin_a_o,
   output logic output_pin_a_oe_o,
   output logic output_pin_b_o,
   output logic output_pin_b_oe_o,
   // Sticky match flags
   output logic match_a_flag_o,
   output logic match_b_flag_o,
   output logic match_p_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   logic [DATA_W-1:0] timer_control_one_q; // Channel A, run, period setup
   logic [DATA_W-1:0] timer_control_two_q; // Channel B setup
   logic [CNT_W-1:0] compare_a_value_q; // Compare A, ten bits
   logic [CNT_W-1:0] compare_b_value_q; // Compare B, ten bits
   logic run_prev_q; // Run bit one cycle ago
   logic [DATA_W-1:0] rdata_d; // Read mux

   // Decoded fields
   logic [1:0] chan_a_mode_sel;
   logic [1:0] chan_b_mode_sel;
   logic [1:0] chan_a_output_action;
   logic [1:0] chan_b_output_action;
   logic chan_a_output_ctrl;
   logic chan_b_output_ctrl;
   logic chan_a_polarity;
   logic chan_b_polarity;
   logic period_source_sel;
   logic counter_run;
   logic [2:0] period_code;
   logic [1:0] pwm_align_sel;

   // Derived controls
   logic pwm_mode; // Both channels in PWM mode
   logic centre; // Up/down counting
   logic step; // One counting step this cycle
   logic match_a;
   logic match_b;
   logic match_p;
   logic flag_wr; // Write to the flag register

   etc_link_if link ();

   // Field of a channel control word
   function automatic logic [1:0] field2(input logic [DATA_W-1:0] w, input int lo);
      field2 = w[lo +: 2];
   endfunction

   always_comb begin
      chan_a_mode_sel = field2(timer_control_one_q, F_MODE_LO);
      chan_b_mode_sel = field2(timer_control_two_q, F_MODE_LO);
      chan_a_output_action = field2(timer_control_one_q, F_ACTION_LO);
      chan_b_output_action = field2(timer_control_two_q, F_ACTION_LO);
      chan_a_output_ctrl = timer_control_one_q[F_OUT_CTRL];
      chan_b_output_ctrl = timer_control_two_q[F_OUT_CTRL];
      chan_a_polarity = timer_control_one_q[F_POLARITY];
      chan_b_polarity = timer_control_two_q[F_POLARITY];
      period_source_sel = timer_control_one_q[F_PSEL];
      counter_run = timer_control_one_q[F_RUN];
      period_code = timer_control_one_q[F_PCODE_LO +: 3];
      pwm_align_sel = field2(timer_control_one_q, F_ALIGN_LO);
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode and stepping; counting ignores the action fields
   always_comb begin
      pwm_mode = (chan_a_mode_sel == MODE_PWM) && (chan_b_mode_sel == MODE_PWM);
      centre = pwm_mode && (pwm_align_sel != ALIGN_EDGE);
      step = ce_i && tick_i && counter_run && run_prev_q;
      link.start = ce_i && counter_run && !run_prev_q;
      flag_wr = ce_i && wr_i && (addr_i == ADDR_FLAGS);
   end

   // Run edge detector
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         run_prev_q <= 1'b0;
      end else if (ce_i) begin
         run_prev_q <= counter_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         timer_control_one_q <= RST_CTRL_ONE;
         timer_control_two_q <= RST_CTRL_TWO;
         compare_a_value_q <= RST_CMP;
         compare_b_value_q <= RST_CMP;
      end else if (ce_i && wr_i) begin
         case (addr_i)
            ADDR_CTRL_ONE: timer_control_one_q <= wdata_i;
            ADDR_CTRL_TWO: timer_control_two_q <= {10'h000, wdata_i[5:0]};
            ADDR_CMP_A: compare_a_value_q <= wdata_i[CNT_W-1:0];
            ADDR_CMP_B: compare_b_value_q <= wdata_i[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // Sticky flags: write one clears, a new match wins over the clear
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         match_a_flag_o <= 1'b0;
         match_b_flag_o <= 1'b0;
         match_p_flag_o <= 1'b0;
      end else begin
         if (match_a) begin
            match_a_flag_o <= 1'b1;
         end else if (flag_wr && wdata_i[F_FLAG_A]) begin
            match_a_flag_o <= 1'b0;
         end
         if (match_b) begin
            match_b_flag_o <= 1'b1;
         end else if (flag_wr && wdata_i[F_FLAG_B]) begin
            match_b_flag_o <= 1'b0;
         end
         if (match_p) begin
            match_p_flag_o <= 1'b1;
         end else if (flag_wr && wdata_i[F_FLAG_P]) begin
            match_p_flag_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped words read zero
   always_comb begin
      rdata_d = '0;
      case (addr_i)
         ADDR_CTRL_ONE: rdata_d = timer_control_one_q;
         ADDR_CTRL_TWO: rdata_d = timer_control_two_q;
         ADDR_CMP_A: rdata_d = {6'h00, compare_a_value_q};
         ADDR_CMP_B: rdata_d = {6'h00, compare_b_value_q};
         ADDR_COUNT: rdata_d = {6'h00, link.cnt[CNT_W-1:0]};
         ADDR_FLAGS: rdata_d = {13'h0000, match_p_flag_o, match_b_flag_o, match_a_flag_o};
         default: rdata_d = '0;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= rd_i ? rdata_d : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and comparators
   etc_counter u_counter (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .step_i(step),
      .centre_i(centre),
      .align_i(pwm_align_sel),
      .psel_i(period_source_sel),
      .pcode_i(period_code),
      .cmp_a_i(compare_a_value_q),
      .cmp_b_i(compare_b_value_q),
      .link(link),
      .match_a_o(match_a),
      .match_b_o(match_b),
      .match_p_o(match_p)
   );

   // Channel A loses its waveform when compare A sets the period
   etc_channel u_chan_a (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .mode_i(chan_a_mode_sel),
      .action_i(chan_a_output_action),
      .out_ctrl_i(chan_a_output_ctrl),
      .polarity_i(chan_a_polarity),
      .cmp_i(compare_a_value_q),
      .no_pwm_i(period_source_sel),
      .match_i(match_a),
      .link(link),
      .pin_o(output_pin_a_o),
      .pin_oe_o(output_pin_a_oe_o)
   );

   etc_channel u_chan_b (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .mode_i(chan_b_mode_sel),
      .action_i(chan_b_output_action),
      .out_ctrl_i(chan_b_output_ctrl),
      .polarity_i(chan_b_polarity),
      .cmp_i(compare_b_value_q),
      .no_pwm_i(1'b0),
      .match_i(match_b),
      .link(link),
      .pin_o(output_pin_b_o),
      .pin_oe_o(output_pin_b_oe_o)
   );

endmodule

//--- tb/etc_top_chk.sv
// Purpose: port-level checks for etc_top
// Assumes: control shadows mirror bus writes
// Notes: sees only the top ports
`timescale 1ns/10ps
module etc_top_chk
   import etc_pkg::*;
(
   // Clock, reset, strobes
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic tick_i,
   // Register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   // Pins and flags
   input wire logic output_pin_a_o,
   input wire logic output_pin_a_oe_o,
   input wire logic output_pin_b_o,
   input wire logic output_pin_b_oe_o,
   input wire logic match_a_flag_o,
   input wire logic match_b_flag_o,
   input wire logic match_p_flag_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////
   logic [DATA_W-1:0] c1_q; // Control one as written
   logic [5:0] c2_q; // Control two, live bits
   logic quiet_a; // Pin A compare, no action, running
   assign quiet_a = c1_q[1:0] == MODE_COMPARE && c1_q[3:2] == ACT_NONE && c1_q[F_RUN];
   // Shadows come from the bus only, so body slips cannot hide
   always_ff @(posedge core_clk_i) begin
      if (srst_i) c1_q <= RST_CTRL_ONE;
      else if (wr_i && ce_i && addr_i == ADDR_CTRL_ONE) c1_q <= wdata_i;
   end
   // Second shadow, six stored bits
   always_ff @(posedge core_clk_i) begin
      if (srst_i) c2_q <= RST_CTRL_TWO[5:0];
      else if (wr_i && ce_i && addr_i == ADDR_CTRL_TWO) c2_q <= wdata_i[5:0];
   end
   ////////////////////////////////////////
   a_read_idle: assert property (!$past(rd_i) && $past(ce_i) |-> rdata_o == 16'h0000)
      else $error("read data not idle");
   a_ctrl_readback: assert property ($past(rd_i) && $past(ce_i) && $past(addr_i) == ADDR_CTRL_ONE
      |-> rdata_o == $past(c1_q)) else $error("control one read back wrong");
   a_timer_no_oe: assert property (
      c1_q[1:0] == MODE_TIMER && $past(c1_q[1:0]) == MODE_TIMER && $past(ce_i) |-> !output_pin_a_oe_o)
      else $error("pin A driven in timer mode");
   a_cmp_oe_b: assert property (
      !$past(srst_i) && $past(ce_i) && c2_q[1:0] == MODE_COMPARE && $past(c2_q[1:0]) == MODE_COMPARE
      |-> output_pin_b_oe_o) else $error("pin B not driven in compare mode");
   a_p_never: assert property (
      c1_q[F_PSEL] && $past(c1_q[F_PSEL]) && $past(c1_q[F_PSEL], 2) && !$past(match_p_flag_o)
      |-> !match_p_flag_o) else $error("P flag with period select high");
   a_flag_hold: assert property (
      $past(match_a_flag_o) && !$past(srst_i)
      && !($past(wr_i) && $past(addr_i) == ADDR_FLAGS && $past(wdata_i[F_FLAG_A]))
      |-> match_a_flag_o) else $error("A flag dropped without clear");
   a_ce_freeze: assert property (!$past(ce_i) && !$past(srst_i)
      |-> $stable(output_pin_b_o) && $stable(match_b_flag_o) && $stable(rdata_o))
      else $error("state moved with enable low");
   a_none_hold: assert property (
      quiet_a && $past(quiet_a) && $past(quiet_a, 2) |-> $stable(output_pin_a_o))
      else $error("pin A moved with no action");
   a_pwm_force: assert property (
      c2_q[1:0] == MODE_PWM && c2_q[3:2] == ACT_PWM_ACT && $stable(c2_q) && $past(c2_q, 2) == c2_q
      && $past(ce_i) && $past(ce_i, 2) |-> output_pin_b_o == (c2_q[F_OUT_CTRL] ^ c2_q[F_POLARITY]))
      else $error("pin B not forced active");
   // Main scenarios reached
   c_flag_a: cover property ($rose(match_a_flag_o));
   c_flag_p: cover property ($rose(match_p_flag_o));
   c_oe_off: cover property ($fell(output_pin_a_oe_o));
endmodule

bind etc_top etc_top_chk u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .tick_i(tick_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .output_pin_a_o(output_pin_a_o), .output_pin_a_oe_o(output_pin_a_oe_o), .output_pin_b_o(output_pin_b_o),
   .output_pin_b_oe_o(output_pin_b_oe_o), .match_a_flag_o(match_a_flag_o),
   .match_b_flag_o(match_b_flag_o), .match_p_flag_o(match_p_flag_o));

//--- tb/etc_load.sv
// Purpose: load on one timer pin, measures pulse shape
// Assumes: pin pulled low while released
// Notes: figures are core clock cycles, last full period
`timescale 1ns/10ps
module etc_load (
   // Clock and pin
   input wire logic clk_i,
   input wire logic pin_i,
   input wire logic oe_i,
   // Measured shape
   output int hi_o,
   output int per_o
);
   logic lvl; // Level seen on the wire
   logic lvl_q = 1'b0; // Previous level
   int hi_c = 0; // High cycles this period
   int per_c = 0; // Cycles since last rise
   assign lvl = oe_i ? pin_i : 1'b0;
   // Rise to rise span and high time
   always @(posedge clk_i) begin
      lvl_q <= lvl;
      per_c <= per_c + 1;
      if (lvl) hi_c <= hi_c + 1;
      if (lvl && !lvl_q) begin
         per_o <= per_c;
         hi_o <= hi_c;
         per_c <= 1;
         hi_c <= 1;
      end
   end
endmodule

//--- tb/enhanced_timer_compare_pwm_test.sv
// Purpose: self-checking bench for etc_top
// Assumes: tick every cycle unless stated
// Notes: PWM shapes measured by two load models
`timescale 1ns/10ps
module enhanced_timer_compare_pwm_test;
   import etc_pkg::*;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce_i = 1'b1;
   logic tick_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 3'h0;
   logic [DATA_W-1:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic pa, pa_oe, pb, pb_oe, fa, fb, fp; // Pins and flags
   int hi_a, per_a, hi_b, per_b; // Measured shapes
   int fails = 0;
   int samples_checked = 0;
   // Compare row: action, initial level, pin after match
   typedef struct packed {logic [1:0] act; logic oc; logic pin;} etc_row_t;
   etc_row_t rows [5] = '{'{ACT_NONE, 1'b1, 1'b1}, '{ACT_LOW, 1'b1, 1'b0}, '{ACT_HIGH, 1'b0, 1'b1},
      '{ACT_TOGGLE, 1'b1, 1'b0}, '{ACT_TOGGLE, 1'b0, 1'b1}};
   always #4 core_clk_i = ~core_clk_i;
   etc_top DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .tick_i(tick_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .output_pin_a_o(pa),
      .output_pin_a_oe_o(pa_oe), .output_pin_b_o(pb), .output_pin_b_oe_o(pb_oe),
      .match_a_flag_o(fa), .match_b_flag_o(fb), .match_p_flag_o(fp));
   etc_load u_ld_a (.clk_i(core_clk_i), .pin_i(pa), .oe_i(pa_oe), .hi_o(hi_a), .per_o(per_a));
   etc_load u_ld_b (.clk_i(core_clk_i), .pin_i(pb), .oe_i(pb_oe), .hi_o(hi_b), .per_o(per_b));
   ////////////////////////////////////////
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   // One-cycle strobes, changed just after an edge
   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Stop, clear flags, load controls, restart, settle
   task automatic cfg(input logic [DATA_W-1:0] c1, input logic [DATA_W-1:0] c2, input int n);
      bus_wr(ADDR_CTRL_ONE, 16'h0000);
      bus_wr(ADDR_FLAGS, 16'h0007);
      bus_wr(ADDR_CTRL_TWO, c2);
      bus_wr(ADDR_CTRL_ONE, c1);
      cycles(n);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, well past the expected run length
   initial begin
      repeat (40000) @(posedge core_clk_i);
      fails++;
      summarize();
   end
   ////////////////////////////////////////
   initial begin
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] q;
      repeat (12) @(posedge core_clk_i);
      srst_i <= 1'b0;
      // Reset values, unmapped words read zero
      for (int a = 0; a < 8; a++) begin
         bus_rd(a[2:0], d);
         check(d, 16'h0000);
      end
      bus_wr(ADDR_CMP_A, 16'hffff);
      bus_rd(ADDR_CMP_A, d);
      check(d, 16'h03ff);
      bus_wr(ADDR_CTRL_TWO, 16'hffff);
      bus_rd(ADDR_CTRL_TWO, d);
      check(d, 16'h003f);
      check(pb_oe, 1'b0);
      bus_wr(ADDR_CMP_A, 16'h0000);
      bus_wr(ADDR_CMP_B, 16'h0008);
      // Compare actions on pin B, pin A left alone
      foreach (rows[i]) begin
         cfg(16'h0080, {11'h000, rows[i].oc, rows[i].act, MODE_COMPARE}, 3);
         check(pb, rows[i].oc);
         for (int k = 0; k < 40 && fb !== 1'b1; k++) cycles(1);
         check(fb, 1'b1);
         check(pb, rows[i].pin);
         check(pa, 1'b0);
      end
      // Period from compare A: no P flag even with a short code
      bus_wr(ADDR_CMP_A, 16'h00c8);
      cfg(16'h01c0, 16'h0000, 450);
      check({fa, fp}, 2'b10);
      bus_rd(ADDR_COUNT, d);
      check(d < 16'h00c8, 1'b1);
      bus_wr(ADDR_CMP_A, 16'h0005);
      cfg(16'h0180, 16'h0000, 300);
      check({fa, fp}, 2'b11);
      // Edge PWM, period from code, dual duty
      bus_wr(ADDR_CMP_A, 16'h0014);
      bus_wr(ADDR_CMP_B, 16'h0032);
      cfg(16'h019a, 16'h001a, 400);
      check({per_a[15:0], hi_a[15:0]}, {16'h0080, 16'h0014});
      check({per_b[15:0], hi_b[15:0]}, {16'h0080, 16'h0032});
      check({fa, fb, fp}, 3'h7);
      // Centre PWM, both directions
      cfg(16'h199a, 16'h001a, 700);
      check({per_a[15:0], hi_a[15:0]}, {16'h0100, 16'h0027});
      check(hi_b, 16'h0063);
      cfg(16'h199a, 16'h003a, 700);
      check(hi_b, 16'h009d);
      // Forced active level, counting goes on
      cfg(16'h199a, 16'h0016, 700);
      check({pb, fb, fp}, 3'h7);
      // Enable low freezes everything; the checker watches pin B, flag B and the read data
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      ce_i <= 1'b1;
      // Period from compare A, B only
      bus_wr(ADDR_CMP_A, 16'h000a);
      bus_wr(ADDR_CMP_B, 16'h0004);
      cfg(16'h00da, 16'h001a, 100);
      check({per_b[15:0], hi_b[15:0]}, {16'h000a, 16'h0004});
      check(pa, 1'b0);
      cfg(16'h18da, 16'h001a, 100);
      check({per_b[15:0], hi_b[15:0]}, {16'h0014, 16'h0007});
      // Timer mode: flags as compare, pins released
      cfg(16'h0083, 16'h0003, 50);
      check({fa, pa_oe, pb_oe}, 3'h4);
      // No tick, no count
      @(posedge core_clk_i);
      tick_i <= 1'b0;
      bus_rd(ADDR_COUNT, d);
      bus_rd(ADDR_COUNT, q);
      check(q, d);
      // Reset in mid-run clears pins, flags and the count
      @(posedge core_clk_i);
      srst_i <= 1'b1;
      cycles(2);
      check({pa, pa_oe, pb, pb_oe, fa, fb, fp}, 7'h00);
      @(posedge core_clk_i);
      srst_i <= 1'b0;
      bus_rd(ADDR_COUNT, d);
      check(d, 16'h0000);
      summarize();
   end
endmodule
